//--- src/kpg_top.sv
// How it works
// - Four port pins, direction bit one outputs
// - Reads give pin or latch; writes load latch
// - Each pull-up bit enables one pin pull-up
// - Pull-up stays on in output mode
// - Direction clears to input at reset
// - Latch drives pin as soon as output
// - Either interrupt edge sets pending flag
// - Level flag mirrors interrupt pin
// - Key input ports read pin levels
// - Low key input in standby requests release
// - Drive port C latch, low in standby/reset
// - Drive port D behaves like port C
`include "kpg_cfg.svh"

module kpg_top #(
	parameter int W = 4
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Register file access
	input wire kpg_pkg::kpg_addr_t rf_addr,
	input wire logic rf_wr,
	input wire kpg_pkg::kpg_nib_t rf_wdata,
	input wire logic rf_rd,
	output kpg_pkg::kpg_nib_t rf_rdata,
	// Standby
	input wire logic standby,
	output logic standby_release,
	// Bidirectional port pins
	input wire logic [W-1:0] pe_in,
	output logic [W-1:0] pe_out,
	output logic [W-1:0] pe_oe_b,
	output logic [W-1:0] pe_pullup,
	// Key input pins
	input wire logic [W-1:0] ka_in,
	input wire logic [W-1:0] kb_in,
	// Key drive pins, open drain
	output logic [W-1:0] kc_out,
	output logic [W-1:0] kc_oe_b,
	output logic [W-1:0] kd_out,
	output logic [W-1:0] kd_oe_b,
	// External interrupt
	input wire logic int_pin,
	output logic int_pending
);
	import kpg_pkg::*;

	logic rst_s1_b;
	logic rst_sync_b;
	logic [W-1:0] ka_s1;
	logic [W-1:0] ka_s2;
	logic [W-1:0] kb_s1;
	logic [W-1:0] kb_s2;
	logic [W-1:0] drv_c;
	logic [W-1:0] drv_d;
	logic [W-1:0] bd_dir;
	logic [W-1:0] bd_pin_s2;
	logic [W-1:0] bd_rd_val;
	logic int_level;
	logic int_edge;
	logic key_low;
	kpg_src_e rd_src;

	kpg_reg_if rf_bus ();

	// Reset enters asynchronously, but is released on the clock
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			rst_s1_b <= 1'b0;
			rst_sync_b <= 1'b0;
		end else begin
			rst_s1_b <= 1'b1;
			rst_sync_b <= rst_s1_b;
		end
	end

	// Write strobe shared with the two owners
	assign rf_bus.wr = rf_wr;
	assign rf_bus.addr = rf_addr;
	assign rf_bus.wdata = rf_wdata;

	// Bidirectional port
	kpg_bidir #(
		.W(W)
	) u_bidir (
		.clk(clk),
		.rst_sync_b(rst_sync_b),
		.rf(rf_bus),
		.pin_in(pe_in),
		.pin_out(pe_out),
		.pin_oe_b(pe_oe_b),
		.pu_en(pe_pullup),
		.dir(bd_dir),
		.pin_s2(bd_pin_s2),
		.rd_val(bd_rd_val)
	);

	// External interrupt pin
	kpg_extint u_int (
		.clk(clk),
		.rst_sync_b(rst_sync_b),
		.rf(rf_bus),
		.int_pin(int_pin),
		.level(int_level),
		.pending(int_pending),
		.edge_seen(int_edge)
	);

	// Key inputs are asynchronous pins, two stages each
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			ka_s1 <= '1;
			ka_s2 <= '1;
			kb_s1 <= '1;
			kb_s2 <= '1;
		end else begin
			ka_s1 <= ka_in;
			ka_s2 <= ka_s1;
			kb_s1 <= kb_in;
			kb_s2 <= kb_s1;
		end
	end

	// Drive latches clear, so both ports pull low out of reset
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			drv_c <= W'(`KPG_RST_DRV);
		end else if (rf_wr && kpg_hit(rf_addr, `KPG_ADDR_DRV_C)) begin
			drv_c <= rf_wdata[W-1:0];
		end
	end

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			drv_d <= W'(`KPG_RST_DRV);
		end else if (rf_wr && kpg_hit(rf_addr, `KPG_ADDR_DRV_D)) begin
			drv_d <= rf_wdata[W-1:0];
		end
	end

	// Open drain: only a low is driven; standby forces every pin low.
	// Registered so the pins never glitch on decode changes.
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			kc_out <= '0;
			kc_oe_b <= '0;
			kd_out <= '0;
			kd_oe_b <= '0;
		end else begin
			kc_out <= '0;
			kc_oe_b <= standby ? '0 : drv_c;
			kd_out <= '0;
			kd_oe_b <= standby ? '0 : drv_d;
		end
	end

	// Any low key return while in standby asks for wake-up
	assign key_low = ~(&ka_s2) | ~(&kb_s2);

	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			standby_release <= 1'b0;
		end else begin
			standby_release <= standby && key_low;
		end
	end

	// Read answer is held until the next read; unused addresses give 0
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			rf_rdata <= `KPG_RST_UNMAPPED;
			rd_src <= kpg_src_none;
		end else if (rf_rd) begin
			rd_src <= kpg_src_port;
			if (kpg_hit(rf_addr, `KPG_ADDR_DATA)) begin
				rf_rdata <= bd_rd_val;
			end else if (kpg_hit(rf_addr, `KPG_ADDR_DIR)) begin
				rf_rdata <= bd_dir;
			end else if (kpg_hit(rf_addr, `KPG_ADDR_PULLUP)) begin
				rf_rdata <= pe_pullup;
			end else if (kpg_hit(rf_addr, `KPG_ADDR_KEY_A)) begin
				rf_rdata <= ka_s2;
			end else if (kpg_hit(rf_addr, `KPG_ADDR_KEY_B)) begin
				rf_rdata <= kb_s2;
			end else if (kpg_hit(rf_addr, `KPG_ADDR_DRV_C)) begin
				rf_rdata <= drv_c;
			end else if (kpg_hit(rf_addr, `KPG_ADDR_DRV_D)) begin
				rf_rdata <= drv_d;
			end else if (kpg_hit(rf_addr, `KPG_ADDR_IRQ)) begin
				rf_rdata <= {3'h0, int_pending};
				rd_src <= kpg_src_flag;
			end else if (kpg_hit(rf_addr, `KPG_ADDR_LEVEL)) begin
				rf_rdata <= {3'h0, int_level};
				rd_src <= kpg_src_flag;
			end else begin
				rf_rdata <= `KPG_RST_UNMAPPED;
				rd_src <= kpg_src_none;
			end
		end
	end

	// Checks run on the released reset
	default clocking cb @(posedge clk);
	endclocking
	default disable iff (!rst_sync_b);

	// Direction write sets the enables on the next edge
	a_dir_enable: assert property (
		rf_wr && kpg_hit(rf_addr, `KPG_ADDR_DIR) |=> pe_oe_b == ~$past(rf_wdata)
	) else $error("pin enable does not follow direction write");

	// Latch lands on the pins after a data write
	a_latch_out: assert property (
		rf_wr && kpg_hit(rf_addr, `KPG_ADDR_DATA) |=> pe_out == $past(rf_wdata)
	) else $error("output latch not driven after write");

	// Data read mixes latch and pin by direction
	a_data_read: assert property (
		rf_rd && kpg_hit(rf_addr, `KPG_ADDR_DATA)
		|=> rf_rdata == (($past(bd_dir) & $past(pe_out)) | (~$past(bd_dir) & $past(bd_pin_s2)))
	) else $error("data read returns wrong mix");

	// Pull-up untouched by a direction write
	a_pullup_keep: assert property (
		rf_wr && kpg_hit(rf_addr, `KPG_ADDR_DIR) |=> $stable(pe_pullup)
	) else $error("pull-up changed with direction");

	// Any edge on the synchronised pin raises the flag
	a_irq_edge: assert property (
		$changed(int_level) |=> int_pending
	) else $error("pending flag missed an edge");

	// Level read mirrors the pin two stages on
	a_level_read: assert property (
		rf_rd && kpg_hit(rf_addr, `KPG_ADDR_LEVEL) |=> rf_rdata == {3'h0, $past(int_level)}
	) else $error("level flag read wrong");

	// Key port A reads back its synchronised pins
	a_key_read: assert property (
		rf_rd && kpg_hit(rf_addr, `KPG_ADDR_KEY_A) |=> rf_rdata == $past(ka_s2)
	) else $error("key port read wrong");

	// Standby with a key pressed raises release one cycle later
	a_stby_wake: assert property (
		standby && key_low |=> standby_release
	) else $error("standby release missing");

	// Standby pulls both drive ports low on the next edge
	a_stby_low: assert property (
		standby |=> kc_oe_b == '0 && kd_oe_b == '0
	) else $error("drive ports not low in standby");

	// A cleared flag with no new edge stays clear
	a_irq_once: assert property (
		rf_wr && kpg_hit(rf_addr, `KPG_ADDR_IRQ) && !rf_wdata[0] && !int_edge
		|=> !int_pending
	) else $error("pending flag set without an edge");

	// Key port B reads back its synchronised pins
	a_key_b_read: assert property (
		rf_rd && kpg_hit(rf_addr, `KPG_ADDR_KEY_B) |=> rf_rdata == $past(kb_s2)
	) else $error("key port B read wrong");

	// Drive latch C reads back what was written
	a_drv_c_read: assert property (
		rf_rd && kpg_hit(rf_addr, `KPG_ADDR_DRV_C) |=> rf_rdata == $past(drv_c)
	) else $error("drive port C read wrong");

	// Drive latch D reads back what was written
	a_drv_d_read: assert property (
		rf_rd && kpg_hit(rf_addr, `KPG_ADDR_DRV_D) |=> rf_rdata == $past(drv_d)
	) else $error("drive port D read wrong");

	// Out of standby the open-drain enables follow their latches
	a_drv_follow: assert property (
		!standby |=> kc_oe_b == $past(drv_c) && kd_oe_b == $past(drv_d)
	) else $error("drive enables do not follow latches");

	// Open-drain data lines may only ever pull low
	a_drv_no_high: assert property (
		kc_out == '0 && kd_out == '0
	) else $error("open-drain output drives high");

	// Pull-up write lands on the pins on the next edge
	a_pullup_write: assert property (
		rf_wr && kpg_hit(rf_addr, `KPG_ADDR_PULLUP) |=> pe_pullup == $past(rf_wdata)
	) else $error("pull-up write not applied");

	// Direction reads back as written
	a_dir_read: assert property (
		rf_rd && kpg_hit(rf_addr, `KPG_ADDR_DIR) |=> rf_rdata == $past(bd_dir)
	) else $error("direction read wrong");

	// Pending stays set until software clears it
	a_pend_hold: assert property (
		int_pending && !(rf_wr && kpg_hit(rf_addr, `KPG_ADDR_IRQ)) |=> int_pending
	) else $error("pending flag dropped without a clear");

	c_to_output: cover property ($fell(pe_oe_b[0]));
	c_irq_set: cover property ($rose(int_pending));
	c_wake: cover property ($rose(standby_release));
	c_mixed_read: cover property (rf_rd && kpg_hit(rf_addr, `KPG_ADDR_DATA) && bd_dir == 4'h5);
	c_flag_read: cover property (rd_src == kpg_src_flag);
endmodule : kpg_top

//--- src/kpg_cfg.svh
`ifndef KPG_CFG_SVH
`define KPG_CFG_SVH

// Nibble addresses in the control and port space
`define KPG_ADDR_LEVEL 8'h0f
`define KPG_ADDR_PULLUP 8'h17
`define KPG_ADDR_DIR 8'h27
`define KPG_ADDR_IRQ 8'h3e
`define KPG_ADDR_DATA 8'h6f
`define KPG_ADDR_KEY_A 8'h70
`define KPG_ADDR_KEY_B 8'h71
`define KPG_ADDR_DRV_C 8'h72
`define KPG_ADDR_DRV_D 8'h73

// Flag bit positions
`define KPG_BIT_IRQ 0
`define KPG_BIT_LEVEL 0

// Reset values
`define KPG_RST_DIR 4'h0
`define KPG_RST_PULLUP 4'hf
`define KPG_RST_LATCH 4'h0
`define KPG_RST_DRV 4'h0
`define KPG_RST_UNMAPPED 4'h0

`endif

//--- src/kpg_pkg.sv
package kpg_pkg;
	typedef logic [7:0] kpg_addr_t;
	typedef logic [3:0] kpg_nib_t;

	// Source of the last read answer, kept for visibility in waves
	typedef enum logic [1:0] {
		kpg_src_none,
		kpg_src_port,
		kpg_src_flag
	} kpg_src_e;

	// Address match used by every register decoder
	function automatic logic kpg_hit(input kpg_addr_t addr, input kpg_addr_t offset);
		kpg_hit = (addr == offset);
	endfunction : kpg_hit
endpackage : kpg_pkg

//--- src/kpg_reg_if.sv
// Write strobe with address and data, shared by the register owners
interface kpg_reg_if;
	logic wr;
	logic [7:0] addr;
	logic [3:0] wdata;

	modport source (output wr, output addr, output wdata);
	modport sink (input wr, input addr, input wdata);
endinterface : kpg_reg_if

//--- src/kpg_bidir.sv
`include "kpg_cfg.svh"

module kpg_bidir #(
	parameter int W = 4
) (
	// Clock and synchronised reset
	input wire logic clk,
	input wire logic rst_sync_b,
	// Register writes
	kpg_reg_if.sink rf,
	// Pin side
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] pin_out,
	output logic [W-1:0] pin_oe_b,
	output logic [W-1:0] pu_en,
	// State for reads
	output logic [W-1:0] dir,
	output logic [W-1:0] pin_s2,
	output logic [W-1:0] rd_val
);
	import kpg_pkg::*;

	logic [W-1:0] pin_s1;

	// Pin levels cross into the clock domain through two stages
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pin_s1 <= '0;
			pin_s2 <= '0;
		end else begin
			pin_s1 <= pin_in;
			pin_s2 <= pin_s1;
		end
	end

	// Direction and enable move on the same edge, so a bit turned to
	// output drives its existing latch value at once
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			dir <= W'(`KPG_RST_DIR);
			pin_oe_b <= ~W'(`KPG_RST_DIR);
		end else if (rf.wr && kpg_hit(rf.addr, `KPG_ADDR_DIR)) begin
			dir <= rf.wdata[W-1:0];
			pin_oe_b <= ~rf.wdata[W-1:0];
		end
	end

	// Pull-up only follows its own register, never the direction
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pu_en <= W'(`KPG_RST_PULLUP);
		end else if (rf.wr && kpg_hit(rf.addr, `KPG_ADDR_PULLUP)) begin
			pu_en <= rf.wdata[W-1:0];
		end
	end

	// Output latch is written in either mode
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pin_out <= W'(`KPG_RST_LATCH);
		end else if (rf.wr && kpg_hit(rf.addr, `KPG_ADDR_DATA)) begin
			pin_out <= rf.wdata[W-1:0];
		end
	end

	// Read mixes latch for outputs and pin level for inputs
	assign rd_val = (dir & pin_out) | (~dir & pin_s2);
endmodule : kpg_bidir

//--- src/kpg_extint.sv
`include "kpg_cfg.svh"

module kpg_extint (
	// Clock and synchronised reset
	input wire logic clk,
	input wire logic rst_sync_b,
	// Register writes
	kpg_reg_if.sink rf,
	// Interrupt pin
	input wire logic int_pin,
	// Flags
	output logic level,
	output logic pending,
	output logic edge_seen
);
	import kpg_pkg::*;

	logic int_s1;

	// Two stages of synchronisation, a third for the previous level
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			int_s1 <= 1'b0;
			level <= 1'b0;
		end else begin
			int_s1 <= int_pin;
			level <= int_s1;
		end
	end

	// Level lags one stage behind, so the edge term lasts one cycle
	logic level_d;
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			level_d <= 1'b0;
		end else begin
			level_d <= level;
		end
	end
	assign edge_seen = level ^ level_d;

	// An edge in the clearing cycle still sets the flag
	always_ff @(posedge clk or negedge rst_sync_b) begin
		if (!rst_sync_b) begin
			pending <= 1'b0;
		end else if (edge_seen) begin
			pending <= 1'b1;
		end else if (rf.wr && kpg_hit(rf.addr, `KPG_ADDR_IRQ)) begin
			pending <= rf.wdata[`KPG_BIT_IRQ];
		end
	end
endmodule : kpg_extint

//--- verif/kpg_pins_model.sv
// Far side of the port pins: outside drivers, pull-ups and a key matrix
module kpg_pins_model (
	// Device pins
	input wire logic [3:0] pe_out,
	input wire logic [3:0] pe_oe_b,
	input wire logic [3:0] pe_pullup,
	input wire logic [3:0] kc_oe_b,
	input wire logic [3:0] kd_oe_b,
	output logic [3:0] pe_in,
	output logic [3:0] ka_in,
	output logic [3:0] kb_in,
	// Stimulus from the bench
	input wire logic [3:0] ext_en,
	input wire logic [3:0] ext_val,
	input wire logic [3:0] key_a,
	input wire logic [3:0] key_b
);
	timeunit 1ns;
	timeprecision 100ps;
	logic col_low;

	// Device driver wins, then the outside driver, then the pull-up
	always_comb begin
		for (int i = 0; i < 4; i++) begin
			if (!pe_oe_b[i])
				pe_in[i] = pe_out[i];
			else if (ext_en[i])
				pe_in[i] = ext_val[i];
			else if (pe_pullup[i])
				pe_in[i] = 1'b1;
			else
				pe_in[i] = ~pe_out[i]; // Floating: never the stale value
		end
	end

	// A pressed key pulls its return low only while some column is low
	assign col_low = (|(~kc_oe_b)) | (|(~kd_oe_b));
	assign ka_in = ~(key_a & {4{col_low}});
	assign kb_in = ~(key_b & {4{col_low}});
endmodule : kpg_pins_model

//--- verif/tb_top.sv
module tb_top;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk, rst_b, rf_wr, rf_rd, standby, standby_release, int_pin, int_pending;
	logic [7:0] rf_addr;
	logic [3:0] rf_wdata, rf_rdata, pe_in, pe_out, pe_oe_b, pe_pullup, ka_in, kb_in;
	logic [3:0] kc_out, kc_oe_b, kd_out, kd_oe_b, ext_en, ext_val, key_a, key_b;
	logic [3:0] m_lat, m_dir, m_pu, pin_exp;
	logic [31:0] v;
	int seed = 32'hfff9;
	int n_mismatch = 0;
	int n_compared = 0;

	kpg_top u_dut (.clk(clk), .rst_b(rst_b), .rf_addr(rf_addr), .rf_wr(rf_wr),
		.rf_wdata(rf_wdata), .rf_rd(rf_rd), .rf_rdata(rf_rdata), .standby(standby),
		.standby_release(standby_release), .pe_in(pe_in), .pe_out(pe_out),
		.pe_oe_b(pe_oe_b), .pe_pullup(pe_pullup), .ka_in(ka_in), .kb_in(kb_in),
		.kc_out(kc_out), .kc_oe_b(kc_oe_b), .kd_out(kd_out), .kd_oe_b(kd_oe_b),
		.int_pin(int_pin), .int_pending(int_pending));

	kpg_pins_model u_pins (.pe_out(pe_out), .pe_oe_b(pe_oe_b), .pe_pullup(pe_pullup),
		.kc_oe_b(kc_oe_b), .kd_oe_b(kd_oe_b), .pe_in(pe_in), .ka_in(ka_in),
		.kb_in(kb_in), .ext_en(ext_en), .ext_val(ext_val), .key_a(key_a), .key_b(key_b));

	// 40 MHz clock
	always #12.5 clk = ~clk;

	task end_sim;
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask : end_sim

	task chk(input string nm, input logic [3:0] seen, input logic [3:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("FAIL %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk

	// One write strobe; returns just after the taking edge has settled
	task wr(input logic [7:0] a, input logic [3:0] d);
		@(posedge clk);
		rf_wr <= 1'b1;
		rf_addr <= a;
		rf_wdata <= d;
		@(posedge clk);
		rf_wr <= 1'b0;
		#1;
	endtask : wr

	// Answer is registered, so it is sampled after the taking edge
	task rd(input logic [7:0] a, input logic [3:0] exp, input string nm);
		@(posedge clk);
		rf_rd <= 1'b1;
		rf_addr <= a;
		@(posedge clk);
		rf_rd <= 1'b0;
		#1;
		chk(nm, rf_rdata, exp);
	endtask : rd

	// Bounded wait on a status output; a hang ends the run
	task wait_hi(input bit sel);
		int t;
		t = 0;
		while ((sel ? standby_release : int_pending) !== 1'b1 && t < 10) begin
			@(posedge clk);
			#1;
			t++;
		end
		if ((sel ? standby_release : int_pending) !== 1'b1) begin
			chk("wait", {3'h0, (sel ? standby_release : int_pending)}, 4'h1);
			end_sim();
		end
	endtask : wait_hi

	initial begin
		clk = 1'b0;
		rst_b = 1'b0;
		{rf_wr, rf_rd, standby, int_pin} = 4'h0;
		rf_addr = 8'h00;
		{rf_wdata, ext_en, ext_val, key_a, key_b} = 20'h00000;
		repeat (5) @(posedge clk);
		rst_b <= 1'b1;
		repeat (3) @(posedge clk);
		#1;
		chk("pe_oe_b", pe_oe_b, 4'hf);
		chk("kc_oe_b", kc_oe_b, 4'h0);
		chk("kd_oe_b", kd_oe_b, 4'h0);
		chk("kc_out", kc_out, 4'h0);
		chk("kd_out", kd_out, 4'h0);
		rd(8'h27, 4'h0, "dir");
		rd(8'h17, 4'hf, "pullup");
		$display("test reset done");
		// Latch first, then direction, so newly output bits show the old latch
		for (int k = 0; k < 16; k++) begin
			v = $random(seed);
			m_lat = v[3:0];
			m_dir = v[7:4];
			m_pu = v[11:8];
			wr(8'h6f, m_lat);
			wr(8'h17, m_pu);
			wr(8'h27, m_dir);
			chk("pe_oe_b", pe_oe_b, ~m_dir);
			chk("pe_out", pe_out & m_dir, m_lat & m_dir);
			chk("pe_pullup", pe_pullup, m_pu);
			ext_en <= v[15:12];
			ext_val <= v[19:16];
			repeat (4) @(posedge clk);
			pin_exp = (ext_en & ext_val) | (~ext_en & m_pu) | (~ext_en & ~m_pu & ~m_lat);
			rd(8'h6f, (m_dir & m_lat) | (~m_dir & pin_exp), "data");
			rd(8'h27, m_dir, "dir");
		end
		$display("test bidir done");
		// Drive latches read back and show on the open-drain enables
		for (int p = 0; p < 2; p++) begin
			v = $random(seed);
			wr(8'h72 + 8'(p), v[3:0]);
			@(posedge clk);
			#1;
			chk("drv_oe_b", (p == 0) ? kc_oe_b : kd_oe_b, v[3:0]);
			rd(8'h72 + 8'(p), v[3:0], "drv");
		end
		// Columns low: returns show the pressed keys; key port A ignores a write
		wr(8'h72, 4'h0);
		wr(8'h70, 4'h5);
		key_a <= v[7:4];
		key_b <= v[11:8];
		repeat (4) @(posedge clk);
		rd(8'h70, ~v[7:4], "key_a");
		rd(8'h71, ~v[11:8], "key_b");
		// Standby forces columns low and a pressed key asks for release
		wr(8'h72, 4'hf);
		wr(8'h73, 4'hf);
		key_a <= 4'h0;
		key_b <= 4'h0;
		standby <= 1'b1;
		repeat (4) @(posedge clk);
		#1;
		chk("kc_oe_b", kc_oe_b, 4'h0);
		chk("kd_oe_b", kd_oe_b, 4'h0);
		chk("release", {3'h0, standby_release}, 4'h0);
		key_b <= 4'h4;
		wait_hi(1'b1);
		standby <= 1'b0;
		key_b <= 4'h0;
		$display("test key ports done");
		// Each edge of the interrupt pin sets the flag once
		int_pin <= 1'b1;
		wait_hi(1'b0);
		rd(8'h3e, 4'h1, "irq");
		rd(8'h0f, 4'h1, "level");
		wr(8'h3e, 4'h0);
		repeat (6) @(posedge clk);
		#1;
		chk("pending", {3'h0, int_pending}, 4'h0);
		int_pin <= 1'b0;
		wait_hi(1'b0);
		rd(8'h0f, 4'h0, "level");
		// Software clear and software set of the pending flag
		wr(8'h3e, 4'h0);
		rd(8'h3e, 4'h0, "irq_clr");
		wr(8'h3e, 4'h1);
		rd(8'h3e, 4'h1, "irq_set");
		rd(8'h55, 4'h0, "unmapped");
		$display("test interrupt done");
		end_sim();
	end
endmodule : tb_top
